//--- design/rx_descriptor_ring.sv
// receive descriptor ring engine: fetches, fills and hands back entries
// assumes a host memory port holding each request until mem_ack, and an
// avalon-mm master that holds each access until waitrequest is low
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "rx_desc_params.svh"

// What the descriptor rules ask of this block and of software
// RQ1 - owner bit 15 set means ours; clear it once the buffer is filled
// RQ2 - software sets owner back to one only after emptying the buffer
// RQ3 - whoever gave up an entry leaves all four words alone until returned
// RQ4 - error summary bit 14 is the or of framing, overflow, crc, buffer
// RQ5 - only we set status bits, only software clears them
// RQ6 - framing bit 13 only when crc failed and length was not whole bytes
// RQ7 - overflow bit 12 when the receive fifo overflowed and data was lost
// RQ8 - crc bit 11 when the frame check sequence mismatched, else zero
// RQ9 - buffer bit 10 when chaining finds next entry not ours or too late
// RQ10 - first-buffer bit 9 set only in the first buffer of a packet
// RQ11 - last-buffer bit 8 set only in the last buffer of a packet
// RQ12 - a packet in one buffer gets both first and last bits
// RQ13 - buffer address is high byte of word 1 joined to the low half
// RQ14 - the high pointer byte is written back unchanged with the status
// RQ15 - low pointer half comes from word 0 and is never written
// RQ16 - byte count is written only for error-free last buffers
// RQ17 - look at most one entry ahead of the current one
// RQ18 - status and cleared owner bit go out in one single word write
module rx_descriptor_ring #(
	parameter int POLL_CYCLES = `RXD_POLL_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	output logic             mem_req,
	output logic             mem_write,
	output logic      [23:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             buf_valid,
	output logic      [23:0] buf_addr,
	input  wire logic        rx_chain,
	input  wire logic        rx_end,
	input  wire logic        rx_crc_error,
	input  wire logic        rx_misaligned,
	input  wire logic        rx_fifo_overflow,
	input  wire logic [11:0] rx_byte_count,
	output logic             rx_abort
);
	logic                  rst_n;
	status_word_if         sw ();

	// bus slave state
	logic                  bus_ack;
	logic                  next_bus_ack;
	logic [31:0]           next_readdata;
	logic [7:0]            ctrl;
	logic [7:0]            next_ctrl;
	rx_desc_pkg::addr_t    ring_base;
	rx_desc_pkg::addr_t    next_ring_base;
	logic [2:0]            irq_status;
	logic [2:0]            next_irq_status;
	logic [2:0]            irq_enable;
	logic [2:0]            next_irq_enable;
	logic                  poll_demand;
	logic                  next_poll_demand;

	// engine state
	rx_desc_pkg::state_e   state;
	rx_desc_pkg::state_e   next_state;
	logic [6:0]            idx;
	logic [6:0]            next_idx;
	logic [7:0]            high;
	logic [7:0]            next_high;
	logic [7:0]            ahead_high;
	logic [7:0]            next_ahead_high;
	logic [15:0]           low;
	logic [15:0]           next_low;
	logic                  first;
	logic                  next_first;
	logic                  last;
	logic                  next_last;
	logic                  crc;
	logic                  next_crc;
	logic                  misal;
	logic                  next_misal;
	logic                  fifo_overflow_flag;
	logic                  next_ovr;
	logic                  buf_err;
	logic                  next_buf_err;
	logic                  chain_go;
	logic                  next_chain_go;
	logic                  next_mem_write;
	logic [23:0]           next_mem_addr;
	logic [15:0]           next_mem_wdata;
	logic                  next_rx_abort;
	logic [2:0]            irq_set;
	logic [15:0]           poll_cnt;
	logic [15:0]           next_poll_cnt;
	logic                  poll_tick;
	logic [6:0]            ring_mask;
	logic [6:0]            idx_next_entry;
	logic                  access;
	logic                  wr_ok;

	reset_sync u_reset_sync (
		.clk    (clk),
		.resetn (resetn),
		.rst_n  (rst_n)
	);

	status_word_former u_former (
		.sw (sw.former)
	);

	assign sw.crc_error    = crc; // RQ8
	assign sw.misaligned   = misal;
	assign sw.overflow     = fifo_overflow_flag; // RQ7
	assign sw.buffer_error = buf_err; // RQ9
	assign sw.first        = first; // RQ10
	assign sw.last         = last; // RQ11
	assign sw.high         = high; // RQ14

	function automatic rx_desc_pkg::addr_t entry_addr(input logic [23:0] base,
		input logic [6:0] i, input logic [2:0] off);
		entry_addr = base + {14'h0000, i, 3'h0} + {21'h000000, off};
	endfunction

	// ring length is a power of two up to 128 entries
	always_comb begin
		ring_mask      = 7'((8'h01 << ctrl[`CTRL_LEN_MSB:`CTRL_LEN_LSB]) - 8'h01);
		idx_next_entry = (idx + 7'h01) & ring_mask; // RQ17
	end

	// ---------------- bus slave: one wait cycle, then answer
	assign access          = avs_read | avs_write;
	assign avs_waitrequest = access & ~bus_ack;
	assign wr_ok           = avs_write & bus_ack;
	assign irq             = |(irq_status & irq_enable);

	always_comb begin
		next_bus_ack     = access & ~bus_ack;
		next_readdata    = avs_readdata;
		next_ctrl        = ctrl;
		next_ring_base   = ring_base;
		next_irq_enable  = irq_enable;
		next_poll_demand = poll_demand;
		if (avs_read & ~bus_ack) begin
			case (avs_address)
				`REG_CTRL:       next_readdata = {24'h000000, ctrl};
				`REG_RING_BASE:  next_readdata = {8'h00, ring_base};
				`REG_IRQ_STATUS: next_readdata = {29'h00000000, irq_status};
				`REG_IRQ_ENABLE: next_readdata = {29'h00000000, irq_enable};
				`REG_POSITION:   next_readdata = {20'h00000, state != rx_desc_pkg::ST_IDLE,
					4'h0, idx};
				default:         next_readdata = 32'h00000000;
			endcase
		end
		if (state == rx_desc_pkg::ST_RD_W1)
			next_poll_demand = 1'b0;
		if (wr_ok) begin
			case (avs_address)
				`REG_CTRL: begin
					next_ctrl        = avs_writedata[7:0] & 8'h71;
					next_poll_demand = avs_writedata[`CTRL_POLL_BIT];
				end
				`REG_RING_BASE:  next_ring_base  = {avs_writedata[23:3], 3'h0};
				`REG_IRQ_ENABLE: next_irq_enable = avs_writedata[2:0];
				default: ;
			endcase
		end
		// a new event in the clearing cycle stays set
		next_irq_status = irq_status & ~((wr_ok && avs_address == `REG_IRQ_CLEAR) ?
			avs_writedata[2:0] : 3'h0);
		next_irq_status = next_irq_status | irq_set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack      <= 1'b0;
			avs_readdata <= 32'h00000000;
			ctrl         <= `CTRL_RESET;
			ring_base    <= `RING_BASE_RESET;
			irq_status   <= `IRQ_RESET;
			irq_enable   <= `IRQ_RESET;
			poll_demand  <= 1'b0;
		end else begin
			bus_ack      <= next_bus_ack;
			avs_readdata <= next_readdata;
			ctrl         <= next_ctrl;
			ring_base    <= next_ring_base;
			irq_status   <= next_irq_status;
			irq_enable   <= next_irq_enable;
			poll_demand  <= next_poll_demand;
		end
	end

	// ---------------- descriptor engine
	// a stalled ring is re-polled on a slow tick instead of hammering memory
	assign poll_tick = (poll_cnt == 16'(POLL_CYCLES - 1));
	assign mem_req   = (state == rx_desc_pkg::ST_RD_W1) || (state == rx_desc_pkg::ST_RD_W0) ||
		(state == rx_desc_pkg::ST_RD_NEXT) || (state == rx_desc_pkg::ST_WR_CNT) ||
		(state == rx_desc_pkg::ST_WR_STAT);
	assign buf_valid = (state == rx_desc_pkg::ST_WAIT_RX);
	assign buf_addr  = {high, low}; // RQ13

	always_comb begin
		next_state      = state;
		next_idx        = idx;
		next_high       = high;
		next_ahead_high = ahead_high;
		next_low        = low;
		next_first      = first;
		next_last       = last;
		next_crc        = crc;
		next_misal      = misal;
		next_ovr        = fifo_overflow_flag;
		next_buf_err    = buf_err;
		next_chain_go   = chain_go;
		next_mem_write  = mem_write;
		next_mem_addr   = mem_addr;
		next_mem_wdata  = mem_wdata;
		next_rx_abort   = 1'b0;
		irq_set         = 3'h0;
		next_poll_cnt   = poll_tick ? 16'h0000 : poll_cnt + 16'h0001;
		if ((state == rx_desc_pkg::ST_WAIT_RX || state == rx_desc_pkg::ST_RD_NEXT) &&
			rx_fifo_overflow)
			next_ovr = 1'b1; // RQ7
		case (state)
			rx_desc_pkg::ST_IDLE: begin
				if (ctrl[`CTRL_ENABLE_BIT] && (poll_tick || poll_demand)) begin
					next_mem_write = 1'b0;
					next_mem_addr  = entry_addr(ring_base, idx, `RXD_WORD1_OFF);
					next_state     = rx_desc_pkg::ST_RD_W1;
				end
			end
			rx_desc_pkg::ST_RD_W1: begin
				if (mem_ack) begin
					if (!mem_rdata[`RXD_OWN_BIT]) begin // RQ3
						irq_set[`IRQ_STALL_BIT] = 1'b1;
						next_state = rx_desc_pkg::ST_IDLE;
					end else begin
						next_high     = mem_rdata[`RXD_HIGH_MSB:0]; // RQ13
						next_mem_addr = entry_addr(ring_base, idx, `RXD_WORD0_OFF);
						next_state    = rx_desc_pkg::ST_RD_W0;
					end
				end
			end
			rx_desc_pkg::ST_RD_W0: begin
				if (mem_ack) begin
					next_low   = mem_rdata; // RQ15
					next_state = rx_desc_pkg::ST_WAIT_RX;
				end
			end
			rx_desc_pkg::ST_WAIT_RX: begin
				if (rx_end) begin
					next_last  = 1'b1; // RQ11
					next_crc   = rx_crc_error; // RQ8
					next_misal = rx_misaligned; // RQ6
					next_chain_go = 1'b0;
					if (!rx_crc_error && !fifo_overflow_flag && !rx_fifo_overflow && !buf_err) begin
						next_mem_write = 1'b1;
						next_mem_addr  = entry_addr(ring_base, idx, `RXD_WORD3_OFF);
						next_mem_wdata = {4'h0, rx_byte_count}; // RQ16
						next_state     = rx_desc_pkg::ST_WR_CNT;
					end else begin
						next_state = rx_desc_pkg::ST_BUILD;
					end
				end else if (rx_chain) begin
					next_mem_write = 1'b0;
					next_mem_addr  = entry_addr(ring_base, idx_next_entry, `RXD_WORD1_OFF); // RQ17
					next_state     = rx_desc_pkg::ST_RD_NEXT;
				end
			end
			rx_desc_pkg::ST_RD_NEXT: begin
				if (mem_ack) begin
					if (mem_rdata[`RXD_OWN_BIT] && !rx_fifo_overflow && !fifo_overflow_flag) begin
						next_ahead_high = mem_rdata[`RXD_HIGH_MSB:0];
						next_last       = 1'b0; // RQ11
						next_chain_go   = 1'b1;
					end else begin
						// chaining failed: this buffer closes the packet
						next_buf_err  = 1'b1; // RQ9
						next_last     = 1'b1;
						next_chain_go = 1'b0;
						next_rx_abort = 1'b1;
					end
					next_state = rx_desc_pkg::ST_BUILD;
				end
			end
			rx_desc_pkg::ST_WR_CNT: begin
				if (mem_ack)
					next_state = rx_desc_pkg::ST_BUILD;
			end
			rx_desc_pkg::ST_BUILD: begin
				next_mem_write = 1'b1;
				next_mem_addr  = entry_addr(ring_base, idx, `RXD_WORD1_OFF);
				next_mem_wdata = sw.word; // RQ18
				next_state     = rx_desc_pkg::ST_WR_STAT;
			end
			rx_desc_pkg::ST_WR_STAT: begin
				if (mem_ack) begin
					next_idx = idx_next_entry;
					if (chain_go) begin
						next_high      = ahead_high;
						next_first     = 1'b0; // RQ10
						next_mem_write = 1'b0;
						next_mem_addr  = entry_addr(ring_base, idx_next_entry, `RXD_WORD0_OFF);
						next_state     = rx_desc_pkg::ST_RD_W0;
					end else begin
						irq_set[`IRQ_PACKET_BIT] = 1'b1;
						irq_set[`IRQ_ERROR_BIT]  = mem_wdata[`RXD_ERR_BIT];
						next_first   = 1'b1; // RQ12
						next_last    = 1'b0;
						next_crc     = 1'b0;
						next_misal   = 1'b0;
						next_ovr     = 1'b0;
						next_buf_err = 1'b0;
						next_mem_write = 1'b0;
						next_mem_addr  = entry_addr(ring_base, idx_next_entry, `RXD_WORD1_OFF);
						next_state = ctrl[`CTRL_ENABLE_BIT] ? rx_desc_pkg::ST_RD_W1 :
							rx_desc_pkg::ST_IDLE;
					end
				end
			end
			default: next_state = rx_desc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= rx_desc_pkg::ST_IDLE;
			idx        <= 7'h00;
			high       <= 8'h00;
			ahead_high <= 8'h00;
			low        <= 16'h0000;
			first      <= 1'b1;
			last       <= 1'b0;
			crc        <= 1'b0;
			misal      <= 1'b0;
			fifo_overflow_flag        <= 1'b0;
			buf_err    <= 1'b0;
			chain_go   <= 1'b0;
			mem_write  <= 1'b0;
			mem_addr   <= 24'h000000;
			mem_wdata  <= 16'h0000;
			rx_abort   <= 1'b0;
			poll_cnt   <= 16'h0000;
		end else begin
			state      <= next_state;
			idx        <= next_idx;
			high       <= next_high;
			ahead_high <= next_ahead_high;
			low        <= next_low;
			first      <= next_first;
			last       <= next_last;
			crc        <= next_crc;
			misal      <= next_misal;
			fifo_overflow_flag        <= next_ovr;
			buf_err    <= next_buf_err;
			chain_go   <= next_chain_go;
			mem_write  <= next_mem_write;
			mem_addr   <= next_mem_addr;
			mem_wdata  <= next_mem_wdata;
			rx_abort   <= next_rx_abort;
			poll_cnt   <= next_poll_cnt;
		end
	end

	// ---------------- checks
	owner_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
		state == rx_desc_pkg::ST_BUILD |=> mem_write && !mem_wdata[`RXD_OWN_BIT]
		&& mem_addr[2:0] == (ring_base[2:0] + `RXD_WORD1_OFF))
		else $error("status write does not hand the entry back");
	err_summary_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
		state == rx_desc_pkg::ST_WR_STAT |->
		mem_wdata[`RXD_ERR_BIT] == (|mem_wdata[`RXD_FRM_BIT:`RXD_BUF_BIT]))
		else $error("error summary disagrees with the error bits");
	framing_crc_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
		state == rx_desc_pkg::ST_WR_STAT |->
		mem_wdata[`RXD_FRM_BIT] == (crc && misal))
		else $error("framing bit without a crc failure");
	high_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
		state == rx_desc_pkg::ST_WR_STAT |-> mem_wdata[`RXD_HIGH_MSB:0] == high)
		else $error("high pointer byte changed on write back");
	count_good_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
		state == rx_desc_pkg::ST_WR_CNT |-> last && !crc && !fifo_overflow_flag && !buf_err)
		else $error("byte count written for a bad or middle buffer");
	look_ahead_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ17
		state == rx_desc_pkg::ST_RD_NEXT |->
		mem_addr == entry_addr(ring_base, idx_next_entry, `RXD_WORD1_OFF))
		else $error("look-ahead went beyond the next entry");
	buffer_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
		$rose(buf_valid) |-> buf_addr == {high, $past(mem_rdata)})
		else $error("buffer address not formed from both pointer halves");
	single_buffer_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
		state == rx_desc_pkg::ST_WR_STAT && first && last |->
		mem_wdata[`RXD_FIRST_BIT] && mem_wdata[`RXD_LAST_BIT])
		else $error("single buffer packet lacks first or last mark");
	first_mark_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
		state == rx_desc_pkg::ST_WR_STAT && mem_ack && chain_go |=>
		##[1:1000] state == rx_desc_pkg::ST_WR_STAT && !mem_wdata[`RXD_FIRST_BIT])
		else $error("later buffer of a packet marked as first");
	no_word0_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
		mem_req && mem_write |-> mem_addr[2:0] != (ring_base[2:0] + `RXD_WORD0_OFF))
		else $error("low pointer word was written");
endmodule // rx_descriptor_ring

//--- design/rx_desc_params.svh
// constants for the receive descriptor status word engine
// assumes 16-bit host memory words and a byte-addressed 24-bit host space
`ifndef RX_DESC_PARAMS_SVH
`define RX_DESC_PARAMS_SVH

// bit positions inside descriptor word 1
`define RXD_OWN_BIT      15
`define RXD_ERR_BIT      14
`define RXD_FRM_BIT      13
`define RXD_OVR_BIT      12
`define RXD_CRC_BIT      11
`define RXD_BUF_BIT      10
`define RXD_FIRST_BIT    9
`define RXD_LAST_BIT     8
`define RXD_HIGH_MSB     7

// byte offsets of the words inside one 8-byte entry
`define RXD_WORD0_OFF    3'h0
`define RXD_WORD1_OFF    3'h2
`define RXD_WORD3_OFF    3'h6

// register byte offsets on the slave bus
`define REG_CTRL         5'h00
`define REG_RING_BASE    5'h04
`define REG_IRQ_STATUS   5'h08
`define REG_IRQ_ENABLE   5'h0C
`define REG_IRQ_CLEAR    5'h10
`define REG_POSITION     5'h14

// control register fields
`define CTRL_ENABLE_BIT  0
`define CTRL_POLL_BIT    1
`define CTRL_LEN_LSB     4
`define CTRL_LEN_MSB     6

// interrupt status bits
`define IRQ_PACKET_BIT   0
`define IRQ_ERROR_BIT    1
`define IRQ_STALL_BIT    2

// reset values and timing
`define CTRL_RESET       8'h00
`define RING_BASE_RESET  24'h000000
`define IRQ_RESET        3'h0
`define RXD_POLL_CYCLES  1024

`endif

//--- design/rx_desc_pkg.sv
// types shared by the receive descriptor engine
// assumes nothing beyond the parameter header
package rx_desc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_W1,
		ST_RD_W0,
		ST_WAIT_RX,
		ST_RD_NEXT,
		ST_WR_CNT,
		ST_BUILD,
		ST_WR_STAT
	} state_e;
	typedef logic [23:0] addr_t;
endpackage

//--- design/status_word_if.sv
// carries packet status flags to the word former and the formed word back
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface status_word_if;
	logic        crc_error;
	logic        misaligned;
	logic        overflow;
	logic        buffer_error;
	logic        first;
	logic        last;
	logic [7:0]  high;
	logic [15:0] word;
	modport producer (output crc_error, misaligned, overflow, buffer_error, first, last,
		high, input word);
	modport former (input crc_error, misaligned, overflow, buffer_error, first, last,
		high, output word);
endinterface

//--- design/reset_sync.sv
// two-stage release of the asynchronous active-low reset
// assumes resetn may fall at any time and rises asynchronously
`timescale 1ns/1ps
module reset_sync (
	input  wire logic clk,
	input  wire logic resetn,
	output logic      rst_n
);
	logic meta;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta  <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			meta  <= 1'b1;
			rst_n <= meta;
		end
	end
endmodule // reset_sync

//--- design/status_word_former.sv
// builds descriptor word 1 from the packet flags, owner bit always cleared
// assumes registered inputs; output is combinational
`timescale 1ns/1ps
module status_word_former (
	status_word_if.former sw
);
	logic framing_error_flag;
	logic err;

	always_comb begin
		framing_error_flag = sw.crc_error & sw.misaligned; // RQ6
		err = framing_error_flag | sw.overflow | sw.crc_error | sw.buffer_error; // RQ4
		sw.word = {1'b0, err, framing_error_flag, sw.overflow, sw.crc_error, sw.buffer_error,
			sw.first, sw.last, sw.high}; // RQ1 RQ5
	end
endmodule // status_word_former

//--- verification/host_memory_model.sv
// host memory partner: 16-bit words, one ack pulse per request
// assumes each request is held until mem_ack; the bench sets the wait once at each packet end
`timescale 1ns/1ps
module host_memory_model (
	input  wire logic        clk,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic [23:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [1:0]  delay,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	logic [15:0] mem [0:2047];
	logic [1:0]  cnt;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
		cnt = 2'h0;
	end
	// software never touches an entry while the device holds it, so words change only here
	always @(posedge clk) begin
		if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata; // a released bus must not keep showing the last word
			cnt <= 2'h0;
			if (mem_write)
				mem[mem_addr[11:1]] <= mem_wdata;
		end else if (mem_req && cnt >= delay) begin
			mem_ack <= 1'b1;
			if (!mem_write)
				mem_rdata <= mem[mem_addr[11:1]];
		end else if (mem_req)
			cnt <= cnt + 2'h1;
	end
endmodule // host_memory_model

//--- verification/rx_descriptor_ring_tb.sv
// self-checking bench for the receive descriptor ring engine
// assumes the host memory model beside it and a 125 MHz clock
`timescale 1ns/1ps
`include "rx_desc_params.svh"
module rx_descriptor_ring_tb;
	localparam logic [23:0] BASE = 24'h000100;
	logic        clk, resetn, avs_read, avs_write, avs_waitrequest, irq, mem_req, mem_write;
	logic        mem_ack, buf_valid, rx_chain, rx_end, rx_crc_error, rx_misaligned;
	logic        rx_fifo_overflow, rx_abort;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [23:0] mem_addr, buf_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [11:0] rx_byte_count;
	logic [1:0]  mem_delay;
	logic [39:0] expq [$];
	logic [7:0]  hi [8];
	logic [15:0] lo [8];
	int          err_total, checked, aborts, n;
	int          seed = 29;

	rx_descriptor_ring #(.POLL_CYCLES(16)) DUT (
		.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .mem_req(mem_req),
		.mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .buf_valid(buf_valid), .buf_addr(buf_addr),
		.rx_chain(rx_chain), .rx_end(rx_end), .rx_crc_error(rx_crc_error),
		.rx_misaligned(rx_misaligned), .rx_fifo_overflow(rx_fifo_overflow),
		.rx_byte_count(rx_byte_count), .rx_abort(rx_abort));
	host_memory_model mem_model (
		.clk(clk), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .delay(mem_delay), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// the request stands until waitrequest is sampled low; no fixed latency assumed
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 100);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 100)
			err_total++;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(what, {8'h0, exp}, {8'h0, r});
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	function automatic logic [23:0] wa(input int e, input int off);
		return BASE + 24'(e * 8 + off);
	endfunction

	// f is {crc, misaligned, overflow}; framing only counts together with a crc failure
	function automatic logic [15:0] stat(input logic [2:0] f, input logic bf, first, last,
		input logic [7:0] h);
		logic framing_error_flag;
		framing_error_flag = f[2] & f[1];
		return {1'b0, framing_error_flag | f[0] | f[2] | bf, framing_error_flag, f[0], f[2], bf, first, last, h};
	endfunction

	task automatic wait_buf(input int e);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (buf_valid !== 1'b1 && k < 2000);
		if (k >= 2000)
			err_total++;
		check("buf_addr", {16'h0, hi[e], lo[e]}, {16'h0, buf_addr});
	endtask

	task automatic pkt_end(input int e, input logic first, input logic [2:0] f);
		logic [11:0] cnt;
		wait_buf(e);
		cnt = $random(seed);
		mem_delay <= $random(seed);
		if (!(f[2] | f[0]))
			expq.push_back({wa(e, 6), 4'h0, cnt});
		expq.push_back({wa(e, 2), stat(f, 1'b0, first, 1'b1, hi[e])});
		rx_end <= 1'b1;
		{rx_crc_error, rx_misaligned, rx_fifo_overflow} <= f;
		rx_byte_count <= cnt;
		@(posedge clk);
		rx_end <= 1'b0;
		{rx_crc_error, rx_misaligned, rx_fifo_overflow} <= 3'h0;
	endtask

	task automatic chain(input int e, input logic ok);
		wait_buf(e);
		expq.push_back({wa(e, 2), stat(3'h0, !ok, 1'b1, !ok, hi[e])});
		rx_chain <= 1'b1;
		@(posedge clk);
		rx_chain <= 1'b0;
	endtask

	// every write the device makes must be the oldest one still expected
	always @(posedge clk) begin
		if (rx_abort === 1'b1)
			aborts++;
		if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_write === 1'b1) begin
			if (expq.size() == 0)
				check("unexpected write", 40'h0, {mem_addr, mem_wdata});
			else
				check("mem write", expq.pop_front(), {mem_addr, mem_wdata});
		end
	end

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#200000;
		err_total++;
		summarize();
	end

	initial begin
		{resetn, avs_read, avs_write, rx_chain, rx_end} = 5'h00;
		{rx_crc_error, rx_misaligned, rx_fifo_overflow} = 3'h0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		rx_byte_count = 12'h000;
		mem_delay = 2'h0;
		for (int e = 0; e < 8; e++) begin
			hi[e] = $random(seed);
			lo[e] = $random(seed);
			mem_model.mem[wa(e, 2) / 2] = {e < 7, 7'h00, hi[e]};
			mem_model.mem[wa(e, 0) / 2] = lo[e];
		end
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`REG_CTRL, 32'h0, "ctrl reset");
		rd(`REG_RING_BASE, 32'h0, "ring base reset");
		rd(`REG_IRQ_STATUS, 32'h0, "status reset");
		rd(`REG_POSITION, 32'h0, "position reset");
		rd(5'h18, 32'h0, "unmapped read");
		wr(`REG_RING_BASE, {8'h00, BASE});
		rd(`REG_RING_BASE, {8'h00, BASE}, "ring base");
		wr(5'h1C, 32'hFFFFFFFF);
		wr(`REG_IRQ_STATUS, 32'h7);
		rd(`REG_IRQ_STATUS, 32'h0, "status read-only");
		wr(`REG_IRQ_ENABLE, 32'h7);
		rd(`REG_IRQ_ENABLE, 32'h7, "irq enable");
		wr(`REG_CTRL, 32'h33);
		rd(`REG_CTRL, 32'h31, "ctrl poll self-clears");
		pkt_end(0, 1'b1, 3'b010);
		pkt_end(1, 1'b1, 3'b110);
		pkt_end(2, 1'b1, 3'b001);
		pkt_end(3, 1'b1, 3'($random(seed)));
		chain(4, 1'b1);
		pkt_end(5, 1'b0, 3'b000);
		chain(6, 1'b0);
		n = 0;
		do begin
			bus(1'b0, `REG_IRQ_STATUS, 32'h0, q);
			n++;
		end while ((q[2] !== 1'b1 || expq.size() != 0) && n < 100);
		check("irq status", 40'h7, {8'h0, q});
		check("irq level", 40'h1, {39'h0, irq});
		check("abort pulses", 40'h1, 40'(aborts));
		wr(`REG_IRQ_ENABLE, 32'h0);
		@(posedge clk);
		check("irq masked", 40'h0, {39'h0, irq});
		wr(`REG_IRQ_CLEAR, 32'h3);
		wr(`REG_IRQ_ENABLE, 32'h3);
		@(posedge clk);
		check("irq cleared", 40'h0, {39'h0, irq});
		bus(1'b0, `REG_IRQ_STATUS, 32'h0, q);
		check("status cleared", 40'h0, {38'h0, q[1:0]});
		bus(1'b0, `REG_POSITION, 32'h0, q);
		check("position index", 40'h7, {33'h0, q[6:0]});
		summarize();
	end
endmodule // rx_descriptor_ring_tb
